/* core/cfoa_core.sv */
// cfoa_core: status flags, operand addressing and apb register file
`timescale 1ns/1ps
`default_nettype none
module cfoa_core
  import cfoa_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  input wire logic I_CE,
  input wire cfoa_apb_req_type I_APB_REQ,
  input wire logic I_WDT_TIMEOUT,
  output var cfoa_apb_rsp_type O_APB_RSP,
  output logic [7:0] O_FLAGS
);

  cfoa_state_type st_ff;
  cfoa_state_type nxt_st;

  logic setup_ph;
  logic wr_acc;
  logic exec;
  logic [31:0] instr;
  logic [7:0] fa;
  cfoa_op_type op;

  logic [11:0] ea;
  logic virt_hit;
  logic [1:0] pn;
  logic [2:0] kind;
  logic [7:0] x;
  logic [7:0] y;
  logic [7:0] res;
  logic [8:0] sum;
  logic [4:0] nib;
  logic sub;
  logic arith;
  logic logic_op;
  logic rot;
  logic rot_out;
  logic clr;
  logic has_res;
  logic dest_file;
  logic uses_f;

  assign setup_ph = I_APB_REQ.psel & ~I_APB_REQ.penable;
  assign wr_acc = I_APB_REQ.psel & I_APB_REQ.penable & I_APB_REQ.pwrite;
  assign exec = I_CE & wr_acc & (I_APB_REQ.paddr == ADDR_INSTR);
  assign instr = I_APB_REQ.pwdata;
  assign fa = instr[7:0];
  assign op = cfoa_op_type'(instr[OP_HI:OP_LO]);

  // read value and error flag for one word address
  function automatic logic [32:0] reg_read(input logic [7:0] a, input cfoa_state_type s);
    logic [32:0] r;
    r = {1'b0, 32'h0000_0000};
    if (a == ADDR_ARITH) begin
      r[7:0] = {1'b0, s.wdt_timeout_flag_n, s.powerdown_flag_n, s.n, s.overflow_flag, s.z,
                s.digit_carry_flag, s.c};
    end else if (a == ADDR_WREG) begin
      r[7:0] = s.w;
    end else if (a == ADDR_BANK) begin
      r[3:0] = s.bank_select_register;
    end else if (a == ADDR_FP0) begin
      r[11:0] = s.fp[0];
    end else if (a == ADDR_FP1) begin
      r[11:0] = s.fp[1];
    end else if (a == ADDR_FP2) begin
      r[11:0] = s.fp[2];
    end else if (a == ADDR_CFG) begin
      r[0] = s.extended_set_enable;
    end else if (a == ADDR_OPND) begin
      r[7:0] = s.opnd;
    end else if (a == ADDR_INSTR) begin
      r[31:0] = 32'h0000_0000;
    end else if (a == ADDR_RESULT) begin
      r[21:0] = {s.res_suppr, s.res_to_file, s.res_addr, s.res_data};
    end else if (a == ADDR_TARGET) begin
      r[19:0] = s.target;
    end else begin
      r[32] = 1'b1;
    end
    return r;
  endfunction : reg_read

  always_comb begin
    nxt_st = st_ff;
    ea = 12'h000;
    virt_hit = 1'b0;
    pn = 2'd0;
    kind = 3'd0;
    x = 8'h00;
    y = 8'h00;
    res = 8'h00;
    sub = 1'b0;
    arith = 1'b0;
    logic_op = 1'b0;
    rot = 1'b0;
    rot_out = 1'b0;
    clr = 1'b0;
    has_res = 1'b0;
    dest_file = 1'b0;
    uses_f = 1'b0;

    // capture read data in setup so it is a flop output in access
    if (setup_ph) begin
      {nxt_st.pslverr, nxt_st.prdata} = reg_read(I_APB_REQ.paddr, st_ff);
    end

    if (wr_acc) begin
      if (I_APB_REQ.paddr == ADDR_ARITH) begin
        // timeout and power-down bits ignore writes
        {nxt_st.n, nxt_st.overflow_flag, nxt_st.z, nxt_st.digit_carry_flag, nxt_st.c} =
          I_APB_REQ.pwdata[FLAG_N:FLAG_C];
      end else if (I_APB_REQ.paddr == ADDR_WREG) begin
        nxt_st.w = I_APB_REQ.pwdata[7:0];
      end else if (I_APB_REQ.paddr == ADDR_BANK) begin
        nxt_st.bank_select_register = I_APB_REQ.pwdata[3:0];
      end else if (I_APB_REQ.paddr == ADDR_FP0) begin
        nxt_st.fp[0] = I_APB_REQ.pwdata[11:0];
      end else if (I_APB_REQ.paddr == ADDR_FP1) begin
        nxt_st.fp[1] = I_APB_REQ.pwdata[11:0];
      end else if (I_APB_REQ.paddr == ADDR_FP2) begin
        nxt_st.fp[2] = I_APB_REQ.pwdata[11:0];
      end else if (I_APB_REQ.paddr == ADDR_CFG) begin
        nxt_st.extended_set_enable = I_APB_REQ.pwdata[0];
      end else if (I_APB_REQ.paddr == ADDR_OPND) begin
        nxt_st.opnd = I_APB_REQ.pwdata[7:0];
      end
    end

    // timeout applied first so a same-cycle watchdog clear or sleep wins
    if (I_WDT_TIMEOUT) begin
      nxt_st.wdt_timeout_flag_n = 1'b0;
    end

    // direct address formation
    if (instr[A_BIT]) begin
      ea = {st_ff.bank_select_register, fa};
    end else if (st_ff.extended_set_enable && fa < ACCESS_SPLIT) begin
      ea = st_ff.fp[2] + {4'h0, fa};
    end else if (fa < ACCESS_SPLIT) begin
      ea = {4'h0, fa};
    end else begin
      ea = {ACCESS_HI_BANK, fa};
    end

    // virtual operands: pointer in bits 5:4, kind in bits 2:0
    pn = ea[5:4];
    kind = ea[2:0];
    virt_hit = (ea[11:6] == VIRT_TAG) && (pn < NUM_FP) && !ea[3] &&
               (kind <= VK_PLUSW);
    if (virt_hit) begin
      case (cfoa_vkind_type'(kind))
        VK_PREINC: ea = st_ff.fp[pn] + FP_STEP;
        VK_PLUSW: ea = st_ff.fp[pn] + {{4{st_ff.w[7]}}, st_ff.w};
        default: ea = st_ff.fp[pn];
      endcase
    end

    if (exec) begin
      case (op)
        OP_ADDWF: begin
          x = st_ff.opnd;
          y = st_ff.w;
          arith = 1'b1;
          uses_f = 1'b1;
          dest_file = instr[D_BIT];
        end
        OP_SUBWF: begin
          x = st_ff.opnd;
          y = ~st_ff.w;
          sub = 1'b1;
          arith = 1'b1;
          uses_f = 1'b1;
          dest_file = instr[D_BIT];
        end
        OP_ADDLW: begin
          x = fa;
          y = st_ff.w;
          arith = 1'b1;
        end
        OP_SUBLW: begin
          x = fa;
          y = ~st_ff.w;
          sub = 1'b1;
          arith = 1'b1;
        end
        OP_ANDWF: begin
          res = st_ff.opnd & st_ff.w;
          logic_op = 1'b1;
          uses_f = 1'b1;
          dest_file = instr[D_BIT];
        end
        OP_IORWF: begin
          res = st_ff.opnd | st_ff.w;
          logic_op = 1'b1;
          uses_f = 1'b1;
          dest_file = instr[D_BIT];
        end
        OP_XORWF: begin
          res = st_ff.opnd ^ st_ff.w;
          logic_op = 1'b1;
          uses_f = 1'b1;
          dest_file = instr[D_BIT];
        end
        OP_RRCF: begin
          res = {st_ff.c, st_ff.opnd[7:1]};
          rot_out = st_ff.opnd[0];
          rot = 1'b1;
          uses_f = 1'b1;
          dest_file = instr[D_BIT];
        end
        OP_RLCF: begin
          res = {st_ff.opnd[6:0], st_ff.c};
          rot_out = st_ff.opnd[7];
          rot = 1'b1;
          uses_f = 1'b1;
          dest_file = instr[D_BIT];
        end
        OP_CLRF: begin
          res = 8'h00;
          clr = 1'b1;
          uses_f = 1'b1;
          dest_file = 1'b1;
        end
        OP_MOVWF: begin
          res = st_ff.w;
          uses_f = 1'b1;
          dest_file = 1'b1;
        end
        OP_FULL_MOVE: begin
          // destination carried whole from bits 27:16, source taken from opnd; no banking, no pointer side effect
          res = st_ff.opnd;
          ea = instr[DST_HI:DST_LO];
          dest_file = 1'b1;
        end
        OP_CALL: begin
          nxt_st.target = instr[TGT_HI:0];
        end
        OP_SLEEP: begin
          nxt_st.wdt_timeout_flag_n = 1'b1;
          nxt_st.powerdown_flag_n = 1'b0;
        end
        OP_WATCHDOG_CLEAR: begin
          nxt_st.wdt_timeout_flag_n = 1'b1;
          nxt_st.powerdown_flag_n = 1'b1;
        end
        default: res = 8'h00;
      endcase

      sum = 9'({1'b0, x} + {1'b0, y} + {8'h00, sub});
      nib = 5'({1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, sub});
      if (arith) begin
        res = sum[7:0];
      end
      has_res = arith | logic_op | rot | clr | uses_f | (op == OP_FULL_MOVE);

      if (uses_f && virt_hit) begin
        case (cfoa_vkind_type'(kind))
          VK_POST_INCREMENT: nxt_st.fp[pn] = st_ff.fp[pn] + FP_STEP;
          VK_POSTDEC: nxt_st.fp[pn] = st_ff.fp[pn] - FP_STEP;
          VK_PREINC: nxt_st.fp[pn] = st_ff.fp[pn] + FP_STEP;
          default: nxt_st.fp[pn] = st_ff.fp[pn];
        endcase
      end

      if (has_res) begin
        nxt_st.res_data = res;
        nxt_st.res_addr = ea;
        nxt_st.res_to_file = dest_file;
        nxt_st.res_suppr = 1'b0;
        if (!dest_file) begin
          nxt_st.w = res;
        end else if (ea == STATUS_FADDR && (arith | logic_op | rot | clr)) begin
          nxt_st.res_suppr = 1'b1;
        end else if (ea == STATUS_FADDR) begin
          {nxt_st.n, nxt_st.overflow_flag, nxt_st.z, nxt_st.digit_carry_flag, nxt_st.c} =
            res[FLAG_N:FLAG_C];
        end
      end

      if (arith) begin
        nxt_st.n = res[7];
        nxt_st.overflow_flag = (x[7] == y[7]) && (res[7] != x[7]);
        nxt_st.z = (res == 8'h00);
        nxt_st.digit_carry_flag = nib[4];
        nxt_st.c = sum[8];
      end
      if (logic_op | rot) begin
        nxt_st.n = res[7];
        nxt_st.z = (res == 8'h00);
      end
      if (rot) begin
        nxt_st.c = rot_out;
      end
      if (clr) begin
        nxt_st.z = 1'b1;
      end
    end
  end

  // reset is power-on: there is no other reset to hold flags across
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_ff <= ST_RESET;
    end else if (I_CE) begin
      st_ff <= nxt_st;
    end
  end

  assign O_APB_RSP = '{prdata: st_ff.prdata, pready: 1'b1, pslverr: st_ff.pslverr};
  assign O_FLAGS = {1'b0, st_ff.wdt_timeout_flag_n, st_ff.powerdown_flag_n, st_ff.n,
                    st_ff.overflow_flag, st_ff.z, st_ff.digit_carry_flag, st_ff.c};

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);

  sequence s_exec(cfoa_op_type o);
    exec && op == o;
  endsequence

  sequence s_to_w;
    !instr[D_BIT];
  endsequence

  chk_msb_zero: assert property (
    I_CE && setup_ph && I_APB_REQ.paddr == ADDR_ARITH |=> !O_APB_RSP.prdata[7] && !O_FLAGS[7]
  ) else $error("status bit 7 read as one");

  chk_wdt_clear: assert property (
    I_CE && I_WDT_TIMEOUT && !exec |=> !st_ff.wdt_timeout_flag_n
  ) else $error("timeout flag not cleared by watchdog timeout");

  chk_sleep_flags: assert property (
    I_CE and s_exec(OP_SLEEP) |=> st_ff.wdt_timeout_flag_n && !st_ff.powerdown_flag_n
  ) else $error("sleep did not set timeout and clear power-down");

  chk_neg_follows: assert property (
    I_CE and s_exec(OP_ADDWF) and s_to_w |=> st_ff.n == st_ff.w[7]
  ) else $error("negative flag differs from result msb");

  chk_zero_follows: assert property (
    I_CE and s_exec(OP_XORWF) and s_to_w |=> st_ff.z == (st_ff.w == 8'h00)
  ) else $error("zero flag differs from result");

  chk_sub_carry: assert property (
    I_CE and s_exec(OP_SUBWF) and s_to_w
    |=> st_ff.c == ($past(st_ff.opnd) >= $past(st_ff.w))
  ) else $error("subtract carry is not inverted borrow");

  chk_add_digit: assert property (
    I_CE and s_exec(OP_ADDLW)
    |=> st_ff.digit_carry_flag ==
        (({1'b0, $past(fa[3:0])} + {1'b0, $past(st_ff.w[3:0])}) > 5'h0f)
  ) else $error("digit carry wrong after add");

  chk_rotate_carry: assert property (
    I_CE and s_exec(OP_RRCF) |=> st_ff.c == $past(st_ff.opnd[0])
  ) else $error("rotate right did not load carry from bit 0");

  chk_bank_addr: assert property (
    I_CE and s_exec(OP_ADDWF) and instr[A_BIT] && st_ff.bank_select_register != ACCESS_HI_BANK
    |=> st_ff.res_addr == {$past(st_ff.bank_select_register), $past(fa)}
  ) else $error("banked address not formed from bank select");

  chk_full_move: assert property (
    I_CE and s_exec(OP_FULL_MOVE) |=> st_ff.res_addr == $past(instr[DST_HI:DST_LO])
  ) else $error("full-address move used banking");

  chk_post_increment_operand_ptr: assert property (
    I_CE and s_exec(OP_ADDWF) and !instr[A_BIT] && !st_ff.extended_set_enable &&
    fa == {VIRT_TAG[1:0], 6'h01}
    |=> st_ff.fp[0] == 12'($past(st_ff.fp[0]) + FP_STEP) &&
        st_ff.res_addr == $past(st_ff.fp[0])
  ) else $error("post-increment pointer not used then advanced");

  chk_status_guard: assert property (
    I_CE and s_exec(OP_ADDWF) and instr[D_BIT] && ea == STATUS_FADDR
    |=> st_ff.res_suppr && st_ff.z == (8'($past(st_ff.opnd) + $past(st_ff.w)) == 8'h00)
  ) else $error("result written into status by flag operation");

  chk_dest_file: assert property (
    I_CE and s_exec(OP_IORWF) and instr[D_BIT] |=> st_ff.res_to_file && $stable(st_ff.w)
  ) else $error("file destination altered working register");

endmodule : cfoa_core
`default_nettype wire

/* core/cfoa_pkg.sv */
// cfoa_pkg: constants and types for the flags and operand address core
package cfoa_pkg;
  localparam logic [7:0] ADDR_ARITH = 8'h00;
  localparam logic [7:0] ADDR_WREG = 8'h04;
  localparam logic [7:0] ADDR_BANK = 8'h08;
  localparam logic [7:0] ADDR_FP0 = 8'h0c;
  localparam logic [7:0] ADDR_FP1 = 8'h10;
  localparam logic [7:0] ADDR_FP2 = 8'h14;
  localparam logic [7:0] ADDR_CFG = 8'h18;
  localparam logic [7:0] ADDR_OPND = 8'h1c;
  localparam logic [7:0] ADDR_INSTR = 8'h20;
  localparam logic [7:0] ADDR_RESULT = 8'h24;
  localparam logic [7:0] ADDR_TARGET = 8'h28;
  localparam int FLAG_N = 4;
  localparam int FLAG_C = 0;
  localparam int OP_HI = 31;
  localparam int OP_LO = 28;
  localparam int DST_HI = 27;
  localparam int DST_LO = 16;
  localparam int SRC_HI = 11;
  localparam int TGT_HI = 19;
  localparam int D_BIT = 9;
  localparam int A_BIT = 8;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
  localparam logic [11:0] STATUS_FADDR = 12'hff0;
  localparam logic [5:0] VIRT_TAG = 6'h3f;
  localparam logic [1:0] NUM_FP = 2'd3;
  localparam logic [11:0] FP_STEP = 12'h001;
  typedef enum logic [3:0] {
    OP_NOP = 4'b0000, OP_ADDWF = 4'b0001, OP_SUBWF = 4'b0010,
    OP_ADDLW = 4'b0011, OP_SUBLW = 4'b0100, OP_ANDWF = 4'b0101,
    OP_IORWF = 4'b0110, OP_XORWF = 4'b0111, OP_RRCF = 4'b1000,
    OP_RLCF = 4'b1001, OP_FULL_MOVE = 4'b1010, OP_CLRF = 4'b1011,
    OP_CALL = 4'b1100, OP_SLEEP = 4'b1101, OP_WATCHDOG_CLEAR = 4'b1110,
    OP_MOVWF = 4'b1111
  } cfoa_op_type;
  typedef enum logic [2:0] {
    VK_INDIRECT = 3'b000, VK_POST_INCREMENT = 3'b001, VK_POSTDEC = 3'b010,
    VK_PREINC = 3'b011, VK_PLUSW = 3'b100
  } cfoa_vkind_type;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } cfoa_apb_req_type;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cfoa_apb_rsp_type;
  typedef struct packed {
    logic wdt_timeout_flag_n;
    logic powerdown_flag_n;
    logic n;
    logic overflow_flag;
    logic z;
    logic digit_carry_flag;
    logic c;
    logic [7:0] w;
    logic [3:0] bank_select_register;
    logic [2:0][11:0] fp;
    logic extended_set_enable;
    logic [7:0] opnd;
    logic [7:0] res_data;
    logic [11:0] res_addr;
    logic res_to_file;
    logic res_suppr;
    logic [19:0] target;
    logic [31:0] prdata;
    logic pslverr;
  } cfoa_state_type;
  localparam cfoa_state_type ST_RESET = '{wdt_timeout_flag_n: 1'b1, powerdown_flag_n: 1'b1,
                                          default: '0};
endpackage : cfoa_pkg

/* sim/cfoa_core_bench.sv */
// cfoa_core_bench: apb driven self-checking bench for the flags and addressing core
`timescale 1ns/1ps
`default_nettype none
module cfoa_core_bench
  import cfoa_pkg::*;
;
  typedef struct packed {
    cfoa_op_type op;
    logic [7:0] pre;
    logic [7:0] w;
    logic [7:0] val;
    logic [7:0] res;
    logic [7:0] fl;
  } cfoa_alu_case_type;
  typedef struct packed {
    logic xi;
    logic [3:0] bank;
    logic a;
    logic [7:0] f;
    logic [11:0] ea;
  } cfoa_addr_case_type;
  typedef struct packed {
    logic [7:0] f;
    logic [7:0] preg;
    logic [11:0] ea;
    logic [11:0] ptr;
  } cfoa_virt_case_type;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wdt = 1'b0;
  logic ce = 1'b1;
  cfoa_apb_req_type req = '0;
  cfoa_apb_rsp_type rsp;
  logic [7:0] flags;
  int failures = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic err;

  // subtract rows expect carries as inverted borrow
  cfoa_alu_case_type alu_tab [11] = '{
    '{OP_ADDWF, 8'h00, 8'h80, 8'h80, 8'h00, 8'h0d},
    '{OP_ADDLW, 8'h00, 8'h01, 8'h0f, 8'h10, 8'h02},
    '{OP_ADDLW, 8'h00, 8'h01, 8'h7f, 8'h80, 8'h1a},
    '{OP_SUBWF, 8'h00, 8'h05, 8'h05, 8'h00, 8'h07},
    '{OP_SUBWF, 8'h00, 8'h01, 8'h00, 8'hff, 8'h10},
    '{OP_SUBLW, 8'h00, 8'h01, 8'h80, 8'h7f, 8'h09},
    '{OP_ANDWF, 8'h00, 8'h0f, 8'hf0, 8'h00, 8'h04},
    '{OP_IORWF, 8'h00, 8'h01, 8'h80, 8'h81, 8'h10},
    '{OP_XORWF, 8'h0b, 8'hff, 8'hff, 8'h00, 8'h0f},
    '{OP_RRCF, 8'h01, 8'h00, 8'h00, 8'h80, 8'h10},
    '{OP_RLCF, 8'h00, 8'h00, 8'h80, 8'h00, 8'h05}
  };
  cfoa_addr_case_type addr_tab [6] = '{
    '{1'b0, 4'h3, 1'b1, 8'h22, 12'h322},
    '{1'b0, 4'h3, 1'b0, 8'h22, 12'h022},
    '{1'b0, 4'h3, 1'b0, 8'h80, 12'hf80},
    '{1'b1, 4'h3, 1'b0, 8'h05, 12'h205},
    '{1'b1, 4'h3, 1'b0, 8'h60, 12'hf60},
    '{1'b1, 4'h3, 1'b1, 8'h05, 12'h305}
  };
  cfoa_virt_case_type virt_tab [5] = '{
    '{8'hc1, ADDR_FP0, 12'h123, 12'h124},
    '{8'hd2, ADDR_FP1, 12'h456, 12'h455},
    '{8'he3, ADDR_FP2, 12'h800, 12'h800},
    '{8'he0, ADDR_FP2, 12'h800, 12'h800},
    '{8'hc4, ADDR_FP0, 12'h126, 12'h124}
  };

  always #20 clk = ~clk;

  cfoa_core cfoa_core_inst (
    .I_CLOCK(clk),
    .I_RST_N(rst_n),
    .I_CE(ce),
    .I_APB_REQ(req),
    .I_WDT_TIMEOUT(wdt),
    .O_APB_RSP(rsp),
    .O_FLAGS(flags)
  );

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // request held until pready is seen high at a rising edge
  task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    int n;
    @(posedge clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= addr;
    req.pwdata <= wdata;
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) begin
      failures++;
      report_and_stop();
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb_xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb_xfer(1'b1, a, d);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb_xfer(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rchk

  function automatic logic [31:0] ins(input cfoa_op_type op, input logic d, input logic a,
                                      input logic [7:0] f);
    return {op, 18'h0, d, a, f};
  endfunction : ins

  task automatic wdt_pulse();
    @(posedge clk);
    wdt <= 1'b1;
    @(posedge clk);
    wdt <= 1'b0;
  endtask : wdt_pulse

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop();
  end

  initial begin
    int i;
    logic [7:0] f;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rchk(ADDR_ARITH, 32'h60);
    check({24'h0, flags}, 32'h60);
    wr(ADDR_ARITH, 32'hff);
    rchk(ADDR_ARITH, 32'h7f);
    for (i = 0; i < 11; i++) begin
      f = (alu_tab[i].op == OP_ADDLW || alu_tab[i].op == OP_SUBLW) ? alu_tab[i].val : 8'h10;
      wr(ADDR_ARITH, {24'h0, alu_tab[i].pre});
      wr(ADDR_WREG, {24'h0, alu_tab[i].w});
      wr(ADDR_OPND, {24'h0, alu_tab[i].val});
      wr(ADDR_INSTR, ins(alu_tab[i].op, 1'b0, 1'b0, f));
      rchk(ADDR_WREG, {24'h0, alu_tab[i].res});
      rchk(ADDR_ARITH, {24'h0, 8'h60 | alu_tab[i].fl});
    end
    // file-destination writes leave w alone, so w stays zero below
    wr(ADDR_WREG, 32'h0);
    wr(ADDR_OPND, 32'h01);
    wr(ADDR_FP2, 32'h200);
    for (i = 0; i < 6; i++) begin
      wr(ADDR_CFG, {31'h0, addr_tab[i].xi});
      wr(ADDR_BANK, {28'h0, addr_tab[i].bank});
      wr(ADDR_INSTR, ins(OP_ADDWF, 1'b1, addr_tab[i].a, addr_tab[i].f));
      rchk(ADDR_RESULT, {12'h001, addr_tab[i].ea, 8'h01});
      rchk(ADDR_WREG, 32'h0);
    end
    wr(ADDR_CFG, 32'h0);
    wr(ADDR_FP0, 32'h123);
    wr(ADDR_FP1, 32'h456);
    wr(ADDR_FP2, 32'h7ff);
    wr(ADDR_WREG, 32'h02);
    for (i = 0; i < 5; i++) begin
      wr(ADDR_INSTR, ins(OP_ADDWF, 1'b1, 1'b0, virt_tab[i].f));
      rchk(ADDR_RESULT, {12'h001, virt_tab[i].ea, 8'h03});
      rchk(virt_tab[i].preg, {20'h0, virt_tab[i].ptr});
    end
    wr(ADDR_WREG, 32'h0);
    wr(ADDR_OPND, 32'h0);
    wr(ADDR_ARITH, 32'h1b);
    wr(ADDR_INSTR, ins(OP_ADDWF, 1'b1, 1'b0, 8'hf0));
    rchk(ADDR_ARITH, 32'h64);
    apb_xfer(1'b0, ADDR_RESULT, 32'h0);
    check(rd & 32'h0020_0000, 32'h0020_0000);
    wr(ADDR_BANK, 32'h5);
    wr(ADDR_OPND, 32'h3c);
    wr(ADDR_INSTR, {OP_FULL_MOVE, 12'h456, 16'h0});
    apb_xfer(1'b0, ADDR_RESULT, 32'h0);
    check(rd & 32'h000f_ffff, 32'h0004_563c);
    wr(ADDR_INSTR, ins(OP_IORWF, 1'b1, 1'b0, 8'h10));
    rchk(ADDR_WREG, 32'h0);
    wr(ADDR_INSTR, {OP_CALL, 8'h0, 20'habcde});
    rchk(ADDR_TARGET, 32'habcde);
    wr(ADDR_ARITH, 32'h0);
    wr(ADDR_INSTR, ins(OP_SLEEP, 1'b0, 1'b0, 8'h0));
    rchk(ADDR_ARITH, 32'h40);
    wdt_pulse();
    rchk(ADDR_ARITH, 32'h00);
    check({24'h0, flags}, 32'h00);
    wr(ADDR_INSTR, ins(OP_WATCHDOG_CLEAR, 1'b0, 1'b0, 8'h0));
    rchk(ADDR_ARITH, 32'h60);
    wdt_pulse();
    rchk(ADDR_ARITH, 32'h20);
    wr(ADDR_INSTR, ins(OP_SLEEP, 1'b0, 1'b0, 8'h0));
    rchk(ADDR_ARITH, 32'h40);
    // frozen core must ignore a timeout pulse
    @(posedge clk);
    ce <= 1'b0;
    wdt_pulse();
    @(posedge clk);
    ce <= 1'b1;
    check({24'h0, flags}, 32'h40);
    // unmapped slot must error and read zero
    apb_xfer(1'b0, 8'h30, 32'h0);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h1);
    rchk(ADDR_INSTR, 32'h0);
    wr(ADDR_ARITH, 32'h1f);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    check({24'h0, flags}, 32'h60);
    rchk(ADDR_ARITH, 32'h60);
    report_and_stop();
  end
endmodule : cfoa_core_bench
`default_nettype wire
